// ---- include/hwwdt_pkg.sv ----
package hwwdt_pkg;

  // Special-function register addresses.
  localparam logic [7:0] SERVICE_ADDR = 8'hA6;
  localparam logic [7:0] TIMEOUT_SEL_ADDR = 8'hA7;

  // Arming and servicing byte pair.
  localparam logic [7:0] KEY_FIRST = 8'h1E;
  localparam logic [7:0] KEY_SECOND = 8'hE1;

  // Counter layout.
  localparam int BASE_WIDTH = 14;
  localparam int PRESCALE_WIDTH = 7;
  localparam int COUNT_WIDTH = BASE_WIDTH + PRESCALE_WIDTH;
  localparam logic [BASE_WIDTH-1:0] BASE_TERMINAL = 14'h3FFF;

  // Time-out select field.
  localparam int SEL_LSB = 0;
  localparam int SEL_WIDTH = 3;
  localparam logic [SEL_WIDTH-1:0] SEL_RESET = 3'h0;

  // Overflow reset pulse length in peripheral clock periods.
  localparam int PULSE_PERIODS = 96;
  localparam int PULSE_WIDTH = 7;
  localparam logic [PULSE_WIDTH-1:0] PULSE_LAST = 7'(PULSE_PERIODS - 1);

  // Last machine-cycle prescaler count (cycles of 12 and 6 peripheral clocks), standard and double-speed modes.
  localparam int MC_WIDTH = 4;
  localparam logic [MC_WIDTH-1:0] MC_STD_LAST = 4'hB;
  localparam logic [MC_WIDTH-1:0] MC_X2_LAST = 4'h5;

  typedef enum logic [1:0]
  {
    HWWDT_IDLE = 2'b00,
    HWWDT_HALF = 2'b01,
    HWWDT_RUN = 2'b11,
    HWWDT_RUN_HALF = 2'b10
  } hwwdt_state_type;

  typedef struct packed
  {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hwwdt_sfr_type;

endpackage : hwwdt_pkg

// ---- src/hwwdt_sync.sv ----
`timescale 1ns/1ps

// Three-stage synchroniser; a change is taken once stages two and three agree.
module hwwdt_sync
(
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Data
  input wire logic din,
  output logic dout
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      dout <= 1'b1;
    else if (s2_r == s3_r)
      dout <= s3_r;
  end

endmodule : hwwdt_sync

// ---- src/hwwdt_top.sv ----
`timescale 1ns/1ps

// How it works
// - Watchdog core is a 14-bit up-counter hidden from software.
// - After any reset the watchdog is inactive and does not count.
// - Writing 1E then E1 to service register A6 arms the watchdog.
// - Armed counter advances once per machine cycle while oscillator runs.
// - Only hardware reset or watchdog overflow returns it to disabled.
// - The same pair written while armed clears the count to zero.
// - Base configuration overflows and resets at terminal count 3FFF.
// - Overflow drives an active-high reset pulse out on the reset pin.
// - The overflow reset pulse lasts exactly 96 peripheral clock periods.
// - Service register is write-only; reads return an undefined value.
// - A 7-bit prescaler extends the counter for longer time-outs.
// - Three-bit select in bits 2..0 of register A7; bits 7..3 reserved.
// - Select field resets to 000; reserved bits undefined after reset.
// - In power-down the oscillator stops and the counter holds.
// - After interrupt wake from power-down, counting waits for input high.
module hwwdt_top
(
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Special-function register bus
  input wire hwwdt_pkg::hwwdt_sfr_type special_function_register,
  output logic [7:0] sfr_rdata,
  output logic sfr_rvalid,
  // Power management
  input wire logic power_down,
  input wire logic double_speed,
  input wire logic wake_int_n,
  // Reset pin drive and status
  output logic rst_pin_out,
  output logic rst_pin_oe_n,
  output logic armed
);

  hwwdt_pkg::hwwdt_state_type state_r;
  hwwdt_pkg::hwwdt_state_type state_nxt;
  logic [hwwdt_pkg::COUNT_WIDTH-1:0] count_r;
  logic [hwwdt_pkg::SEL_WIDTH-1:0] sel_r;
  logic [hwwdt_pkg::MC_WIDTH-1:0] mc_r;
  logic [hwwdt_pkg::PULSE_WIDTH-1:0] pulse_cnt_r;
  logic pulse_r;
  logic wake_hold_r;
  logic pd_prev_r;
  logic wake_sync;
  logic mc_tick;
  logic svc_wr;
  logic svc_done;
  logic overflow;
  logic is_armed;
  logic [hwwdt_pkg::COUNT_WIDTH-1:0] terminal;

  hwwdt_sync u_wake_sync
  (
    .clock(clock),
    .srst(srst),
    .din(wake_int_n),
    .dout(wake_sync)
  );

  assign svc_wr = special_function_register.wr && (special_function_register.addr == hwwdt_pkg::SERVICE_ADDR);
  assign is_armed = (state_r == hwwdt_pkg::HWWDT_RUN) || (state_r == hwwdt_pkg::HWWDT_RUN_HALF);

  // Sequence detector; any other value on the service address restarts it.
  always_comb
  begin
    state_nxt = state_r;
    svc_done = 1'b0;
    case (state_r)
      hwwdt_pkg::HWWDT_IDLE:
        if (svc_wr && special_function_register.wdata == hwwdt_pkg::KEY_FIRST)
          state_nxt = hwwdt_pkg::HWWDT_HALF;
      hwwdt_pkg::HWWDT_HALF:
        if (svc_wr)
        begin
          if (special_function_register.wdata == hwwdt_pkg::KEY_SECOND)
          begin
            state_nxt = hwwdt_pkg::HWWDT_RUN;
            svc_done = 1'b1;
          end
          else if (special_function_register.wdata != hwwdt_pkg::KEY_FIRST)
            state_nxt = hwwdt_pkg::HWWDT_IDLE;
        end
      hwwdt_pkg::HWWDT_RUN:
        if (svc_wr && special_function_register.wdata == hwwdt_pkg::KEY_FIRST)
          state_nxt = hwwdt_pkg::HWWDT_RUN_HALF;
      hwwdt_pkg::HWWDT_RUN_HALF:
        if (svc_wr)
        begin
          // A broken pair never disarms; it only restarts detection.
          if (special_function_register.wdata == hwwdt_pkg::KEY_SECOND)
          begin
            state_nxt = hwwdt_pkg::HWWDT_RUN;
            svc_done = 1'b1;
          end
          else if (special_function_register.wdata != hwwdt_pkg::KEY_FIRST)
            state_nxt = hwwdt_pkg::HWWDT_RUN;
        end
      default:
        state_nxt = hwwdt_pkg::HWWDT_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (srst || overflow)
      state_r <= hwwdt_pkg::HWWDT_IDLE;
    else
      state_r <= state_nxt;
  end

  // Time-out select register; upper bits are not stored.
  always_ff @(posedge clock)
  begin
    if (srst)
      sel_r <= hwwdt_pkg::SEL_RESET;
    else if (special_function_register.wr && special_function_register.addr == hwwdt_pkg::TIMEOUT_SEL_ADDR)
      sel_r <= special_function_register.wdata[hwwdt_pkg::SEL_LSB +: hwwdt_pkg::SEL_WIDTH];
  end

  // Reads: the select register shows its field, reserved bits as zero.
  // The service register has no read path, so it returns zero as its undefined value.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      sfr_rdata <= 8'h00;
      sfr_rvalid <= 1'b0;
    end
    else
    begin
      sfr_rvalid <= special_function_register.rd;
      if (special_function_register.rd && special_function_register.addr == hwwdt_pkg::TIMEOUT_SEL_ADDR)
        sfr_rdata <= {5'h00, sel_r};
      else
        sfr_rdata <= 8'h00;
    end
  end

  // Machine-cycle prescaler from the peripheral clock; it stops in power-down.
  always_ff @(posedge clock)
  begin
    if (srst)
      mc_r <= '0;
    else if (power_down)
      mc_r <= mc_r;
    else if (mc_tick)
      mc_r <= '0;
    else
      mc_r <= mc_r + 4'h1;
  end

  // A change to double-speed in mid-cycle, with the prescaler already past 5, ends the machine cycle at once rather than letting the
  // prescaler wrap through sixteen clocks; a change to standard mode stretches the cycle to twelve clocks.
  assign mc_tick = !power_down &&
    (mc_r >= (double_speed ? hwwdt_pkg::MC_X2_LAST : hwwdt_pkg::MC_STD_LAST));

  // After leaving power-down, hold counting until the wake input is released high.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pd_prev_r <= 1'b0;
      wake_hold_r <= 1'b0;
    end
    else
    begin
      pd_prev_r <= power_down;
      if (pd_prev_r && !power_down && !wake_sync)
        wake_hold_r <= 1'b1;
      else if (wake_sync)
        wake_hold_r <= 1'b0;
    end
  end

  // Terminal count is 2^(14+sel)-1: the 14-bit base plus sel prescaler bits.
  always_comb
  begin
    terminal = '0;
    for (int i = 0; i < hwwdt_pkg::COUNT_WIDTH; i++)
      if (i < hwwdt_pkg::BASE_WIDTH + int'(sel_r))
        terminal[i] = 1'b1;
  end

  assign overflow = is_armed && mc_tick && !wake_hold_r && (count_r == terminal);

  always_ff @(posedge clock)
  begin
    if (srst || !is_armed || overflow)
      count_r <= '0;
    else if (svc_done)
      count_r <= '0;
    else if (mc_tick && !wake_hold_r)
      count_r <= count_r + 21'h1;
  end

  // Overflow pulse runs on its own counter; a new overflow cannot occur during it.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pulse_r <= 1'b0;
      pulse_cnt_r <= '0;
    end
    else if (overflow)
    begin
      pulse_r <= 1'b1;
      pulse_cnt_r <= '0;
    end
    else if (pulse_r)
    begin
      if (pulse_cnt_r == hwwdt_pkg::PULSE_LAST)
        pulse_r <= 1'b0;
      pulse_cnt_r <= pulse_cnt_r + 7'h1;
    end
  end

  assign rst_pin_out = pulse_r;
  assign rst_pin_oe_n = !pulse_r;
  assign armed = is_armed;

endmodule : hwwdt_top

// ---- tb/hwwdt_props.sv ----
`timescale 1ns/1ps
module hwwdt_props
(
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Bus and pin
  input wire hwwdt_pkg::hwwdt_sfr_type special_function_register,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_rvalid,
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe_n,
  input wire logic armed
);
  logic [7:0] hi_r;
  logic k1;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  assign k1 = special_function_register.wr && special_function_register.addr == hwwdt_pkg::SERVICE_ADDR;
  // The pulse is far longer than a repetition may count, so its width is counted here.
  always_ff @(posedge clock)
  begin
    hi_r <= (srst || !rst_pin_out) ? 8'h00 : hi_r + 8'h01;
  end
  a_idle_quiet: assert property (!armed && !rst_pin_out |=> !rst_pin_out)
    else $error("pulse while idle");
  a_arm_pair: assert property (!armed && k1 && special_function_register.wdata == hwwdt_pkg::KEY_SECOND
    && $past(k1 && special_function_register.wdata == hwwdt_pkg::KEY_FIRST) |=> armed) else $error("not armed");
  a_pulse_start: assert property ($rose(rst_pin_out) |-> $fell(armed))
    else $error("pulse without disarm");
  a_pulse_width: assert property ($fell(rst_pin_out) |-> hi_r == 8'h60)
    else $error("pulse width");
  a_oe_pin: assert property (rst_pin_oe_n != rst_pin_out)
    else $error("pin enable");
  a_stay_armed: assert property ($fell(armed) |-> $rose(rst_pin_out))
    else $error("disarmed without overflow");
  a_read_other: assert property (special_function_register.rd && special_function_register.addr != hwwdt_pkg::TIMEOUT_SEL_ADDR
    |=> sfr_rvalid && sfr_rdata == 8'h00) else $error("read of other address");
  a_read_sel: assert property (special_function_register.rd |=> sfr_rvalid ##0 sfr_rdata[7:3] == 5'h00)
    else $error("reserved bits");
  a_sel_back: assert property (special_function_register.wr && special_function_register.addr == hwwdt_pkg::TIMEOUT_SEL_ADDR
    ##1 special_function_register.rd |=> sfr_rdata[2:0] == $past(special_function_register.wdata[2:0], 2)) else $error("select");
endmodule : hwwdt_props

bind hwwdt_top hwwdt_props chk_i (.clock(clock), .srst(srst), .special_function_register(special_function_register),
  .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid), .rst_pin_out(rst_pin_out),
  .rst_pin_oe_n(rst_pin_oe_n), .armed(armed));

// ---- tb/hwwdt_top_test.sv ----
`timescale 1ns/1ps
module hwwdt_top_test;
  logic clock = 1'b0;
  logic srst = 1'b1;
  hwwdt_pkg::hwwdt_sfr_type special_function_register = '0;
  logic [7:0] sfr_rdata, d;
  logic sfr_rvalid, rst_pin_out, rst_pin_oe_n, armed;
  logic power_down = 1'b0;
  logic wake_int_n = 1'b1;
  logic double_speed = 1'b1;
  int err_total = 0;
  int tests_run = 0;
  int n, w;
  logic [7:0] exp_q[$];
  hwwdt_top dut (.clock(clock), .srst(srst), .special_function_register(special_function_register), .sfr_rdata(sfr_rdata),
    .sfr_rvalid(sfr_rvalid), .power_down(power_down), .double_speed(double_speed),
    .wake_int_n(wake_int_n), .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n),
    .armed(armed));
  initial
  begin
    forever #2 clock = ~clock;
  end
  task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
    tests_run++;
    if (s !== e)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic bus(logic wi, logic ri, logic [7:0] a, logic [7:0] v);
    @(negedge clock);
    special_function_register = '{wi, ri, a, v};
  endtask : bus
  task automatic idle(int c);
    repeat (c) bus(1'b0, 1'b0, 8'h00, 8'h00);
  endtask : idle
  task automatic rd(logic [7:0] a, logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask : rd
  task automatic wr6(logic [7:0] v);
    bus(1'b1, 1'b0, hwwdt_pkg::SERVICE_ADDR, v);
  endtask : wr6
  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  always @(negedge clock)
  begin
    if (sfr_rvalid === 1'b1)
    begin
      chk("read data", sfr_rdata, exp_q.pop_front());
    end
  end
  // The run needs about 99k cycles; this limit leaves a margin of a fifth.
  initial
  begin
    #480000;
    err_total++;
    end_of_test();
  end
  initial
  begin
    d = 8'($urandom(32'hC5CEBEEB));
    repeat (8) @(negedge clock);
    srst = 1'b0;
    rd(hwwdt_pkg::TIMEOUT_SEL_ADDR, 8'h00);
    repeat (4)
    begin
      d = 8'($urandom());
      bus(1'b1, 1'b0, hwwdt_pkg::TIMEOUT_SEL_ADDR, d);
      rd(hwwdt_pkg::TIMEOUT_SEL_ADDR, {5'h00, d[2:0]});
    end
    rd(hwwdt_pkg::SERVICE_ADDR, 8'h00);
    rd(8'h5A, 8'h00);
    bus(1'b1, 1'b0, hwwdt_pkg::TIMEOUT_SEL_ADDR, 8'h00);
    wr6(hwwdt_pkg::KEY_FIRST);
    wr6(8'h00);
    wr6(hwwdt_pkg::KEY_SECOND);
    idle(3);
    chk("armed early", {7'h00, armed}, 8'h00);
    wr6(hwwdt_pkg::KEY_FIRST);
    wr6(hwwdt_pkg::KEY_SECOND);
    idle(3);
    chk("armed", {7'h00, armed}, 8'h01);
    wr6(8'h00);
    idle(3);
    chk("armed kept", {7'h00, armed}, 8'h01);
    $display("register and arming test done");
    // Let the count run up first, so that a service which fails to clear it shows.
    idle(300);
    wr6(hwwdt_pkg::KEY_FIRST);
    wr6(hwwdt_pkg::KEY_SECOND);
    idle(1);
    // Waking with the interrupt line low must keep the count frozen until it rises.
    power_down = 1'b1;
    wake_int_n = 1'b0;
    idle(200);
    power_down = 1'b0;
    double_speed = 1'b0;
    idle(100);
    wake_int_n = 1'b1;
    // The first 300 clocks count at twelve clocks per tick, which adds about half of them.
    idle(300);
    double_speed = 1'b1;
    n = 601;
    while (rst_pin_out !== 1'b1 && n < 120000)
    begin
      idle(1);
      n++;
    end
    chk("overflow time", 8'(n >= 98740 && n <= 98775), 8'h01);
    chk("pin enable", {7'h00, rst_pin_oe_n}, 8'h00);
    w = 0;
    while (rst_pin_out === 1'b1 && w < 200)
    begin
      idle(1);
      w++;
    end
    chk("pulse width", 8'(w), 8'h60);
    chk("armed after", {7'h00, armed}, 8'h00);
    $display("overflow test done");
    end_of_test();
  end
endmodule : hwwdt_top_test
